// File: logic/svwd_top.sv
`timescale 1ns/1ps
`default_nettype none
module svwd_top
  import svwd_pkg::*;
#(
  parameter logic [CNT_W-1:0] WDOG_CNT   = CNT_W'(WDOG_CYCLES),
  parameter logic [CNT_W-1:0] HOLD_CNT   = CNT_W'(HOLD_CYCLES),
  parameter logic [CNT_W-1:0] DEB_CNT    = CNT_W'(DEBOUNCE_CYC),
  parameter bit               HAS_KICK_PIN = 1'b0,
  parameter bit               HAS_HIGH_RST = 1'b1,
  parameter bit               HAS_WP       = 1'b1
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic supply_low_in,
  input  wire logic manual_reset_in,
  input  wire logic watchdog_kick_in,
  input  wire logic sda_in,
  input  wire logic rst_n_pin_in,
  input  wire logic write_protect_in,
  input  wire logic write_req_in,
  output var  logic rst_high_out,
  output var  logic rst_n_pin_out,
  output var  logic rst_n_pin_oe_out,
  output var  logic write_enable_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]             sup_s;
    logic [1:0]             mr_s;
    logic [1:0]             kick_s;
    logic [1:0]             pin_s;
    logic [1:0]             wp_s;
    logic                   kick_last;
    logic                   mr_deb;
    logic [CNT_W-1:0]       deb_cnt;
    logic [CNT_W-1:0]       wd_cnt;
    logic [CNT_W-1:0]       hold_cnt;
    svwd_state_e            state;
    logic                   rst_high;
    logic                   rst_oe;
    logic                   wr_en;
    logic [PIN_BLANK_W-1:0] oe_hist;
  } svwd_s;

  svwd_s r;
  svwd_s next_r;
  logic  kick_src;
  logic  cause;
  logic  pin_live;

  assign kick_src = HAS_KICK_PIN ? watchdog_kick_in : sda_in;

  always_comb begin
    next_r = r;
    // Two-flop synchronisers on every pin input except write_req_in
    next_r.sup_s  = {r.sup_s[0], supply_low_in};
    next_r.mr_s   = {r.mr_s[0], manual_reset_in};
    // RL3 kick source select
    next_r.kick_s = {r.kick_s[0], kick_src};
    next_r.pin_s  = {r.pin_s[0], rst_n_pin_in};
    next_r.wp_s   = {r.wp_s[0], HAS_WP ? write_protect_in : 1'b0};
    next_r.kick_last = r.kick_s[1];
    // RL7 debounce manual
    if (r.mr_s[1] == r.mr_deb) begin
      next_r.deb_cnt = '0;
    end else if (r.deb_cnt >= DEB_CNT - 1'b1) begin
      next_r.deb_cnt = '0;
      next_r.mr_deb  = r.mr_s[1];
    end else begin
      next_r.deb_cnt = r.deb_cnt + 1'b1;
    end
    // RL8 pin pulled low while we release it is an outside request
    next_r.oe_hist = {r.oe_hist[PIN_BLANK_W-2:0], r.rst_oe};
    // Synced pin still shows our own drive just after release
    pin_live = !r.rst_oe && (r.oe_hist == '0);
    cause = r.sup_s[1] || !r.mr_deb || (pin_live && !r.pin_s[1]);
    unique case (r.state)
      SVWD_HOLD: begin
        // RL4 hold active while cause present
        // RL6 also manual reset
        next_r.hold_cnt = '0;
        // RL12 watchdog held clear
        next_r.wd_cnt   = '0;
        if (!cause) begin
          next_r.state = SVWD_TIMEOUT;
        end
      end
      SVWD_TIMEOUT: begin
        // RL5 timeout after cause clears
        next_r.wd_cnt = '0;
        if (cause) begin
          next_r.state    = SVWD_HOLD;
          next_r.hold_cnt = '0;
        end else if (r.hold_cnt >= HOLD_CNT - 1'b1) begin
          next_r.state    = SVWD_RUN;
          next_r.hold_cnt = '0;
        end else begin
          next_r.hold_cnt = r.hold_cnt + 1'b1;
        end
      end
      SVWD_RUN: begin
        if (cause) begin
          next_r.state  = SVWD_HOLD;
          next_r.wd_cnt = '0;
        // RL1 either edge kicks
        end else if (r.kick_s[1] != r.kick_last) begin
          next_r.wd_cnt = '0;
        // RL2 expiry forces reset
        end else if (r.wd_cnt >= WDOG_CNT - 1'b1) begin
          next_r.state  = SVWD_TIMEOUT;
          next_r.wd_cnt = '0;
        end else begin
          next_r.wd_cnt = r.wd_cnt + 1'b1;
        end
      end
      default: begin
        next_r.state = SVWD_HOLD;
      end
    endcase
    // RL11 high output only in variants that have it
    next_r.rst_high = HAS_HIGH_RST && (next_r.state != SVWD_RUN);
    next_r.rst_oe   = next_r.state != SVWD_RUN;
    // RL9 write protect, RL10 supply gate
    next_r.wr_en = write_req_in && !r.wp_s[1] && !r.sup_s[1];
  end

  // Reset state: supply assumed low so writes stay shut until first check
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r          <= '0;
      r.sup_s    <= 2'b11;
      r.mr_s     <= 2'b11;
      r.pin_s    <= 2'b11;
      r.mr_deb   <= 1'b1;
      r.state    <= SVWD_HOLD;
      r.rst_high <= HAS_HIGH_RST;
      r.rst_oe   <= 1'b1;
      r.oe_hist  <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign rst_high_out     = r.rst_high;
  assign rst_n_pin_out    = 1'b0;
  assign rst_n_pin_oe_out = r.rst_oe;
  assign write_enable_out = r.wr_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_supply_hold;
    @(posedge clk_in) disable iff (rst_in) r.sup_s[1] |=> r.rst_oe;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("reset not held"); // RL4

  property p_wr_block;
    @(posedge clk_in) disable iff (rst_in) (r.wp_s[1] || r.sup_s[1]) |=> !write_enable_out;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write not blocked"); // RL9

  property p_wd_clear;
    @(posedge clk_in) disable iff (rst_in) (r.state != SVWD_RUN) |-> r.wd_cnt == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared"); // RL12

  sequence s_kick;
    r.state == SVWD_RUN && !cause && r.kick_s[1] != r.kick_last;
  endsequence
  property p_kick;
    @(posedge clk_in) disable iff (rst_in) s_kick |=> r.wd_cnt == '0;
  endproperty
  a_kick: assert property (p_kick) else $error("kick ignored"); // RL1

  property p_expire;
    @(posedge clk_in) disable iff (rst_in)
      (r.state == SVWD_RUN && !cause && r.kick_s[1] == r.kick_last
       && r.wd_cnt >= WDOG_CNT - 1'b1) |=> ##1 rst_n_pin_oe_out;
  endproperty
  a_expire: assert property (p_expire) else $error("no watchdog reset"); // RL2

  property p_timeout;
    @(posedge clk_in) disable iff (rst_in)
      (r.state == SVWD_TIMEOUT && r.hold_cnt == '0) |-> r.rst_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout released early"); // RL5

  property p_manual;
    @(posedge clk_in) disable iff (rst_in) !r.mr_deb |=> r.rst_oe;
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset lost"); // RL6

  property p_deb;
    @(posedge clk_in) disable iff (rst_in)
      $changed(r.mr_deb) |-> r.mr_deb == $past(r.mr_s[1]) && $past(r.deb_cnt) == DEB_CNT - 1'b1;
  endproperty
  a_deb: assert property (p_deb) else $error("debounce wrong"); // RL7

  property p_release;
    @(posedge clk_in) disable iff (rst_in)
      $fell(r.rst_oe) |-> $past(r.state) == SVWD_TIMEOUT
        && $past(r.hold_cnt) == HOLD_CNT - 1'b1;
  endproperty
  a_release: assert property (p_release) else $error("released before timeout"); // RL5

  property p_pin_req;
    @(posedge clk_in) disable iff (rst_in)
      (r.state == SVWD_RUN && pin_live && !r.pin_s[1]) |=> r.rst_oe;
  endproperty
  a_pin_req: assert property (p_pin_req) else $error("pin request ignored"); // RL8

  property p_kick_src;
    @(posedge clk_in) disable iff (rst_in)
      !$past(rst_in) |-> r.kick_s[0] == $past(kick_src);
  endproperty
  a_kick_src: assert property (p_kick_src) else $error("wrong kick source"); // RL3

  property p_high_variant;
    @(posedge clk_in) disable iff (rst_in)
      rst_high_out == (HAS_HIGH_RST && rst_n_pin_oe_out);
  endproperty
  a_high_variant: assert property (p_high_variant) else $error("high reset mismatch"); // RL11

  property p_wd_fresh;
    @(posedge clk_in) disable iff (rst_in)
      $fell(r.rst_oe) |-> r.wd_cnt == '0;
  endproperty
  a_wd_fresh: assert property (p_wd_fresh) else $error("watchdog not fresh"); // RL12
endmodule
`default_nettype wire

// File: logic/svwd_pkg.sv
// Contract
// RL1 - Any level change on the kick source restarts the watchdog interval.
// RL2 - No kick within 1.6 s asserts reset; controller must kick faster.
// RL3 - Variants without kick pin take kicks from the serial data line.
// RL4 - Supply low drives active-high reset high and active-low reset low.
// RL5 - After supply recovers, resets stay active 200 ms, then release.
// RL6 - Reset held while manual input low, plus full timeout after release.
// RL7 - Manual reset input is debounced before it is acted upon.
// RL8 - Outside pull-low on the reset pin acts as a manual reset request.
// RL9 - Write-protect high blocks all array writes; low or open allows them.
// RL10 - Writes inhibited while supply below threshold, including at power-up.
// RL11 - Variant options: low-only reset, no write-protect, dedicated kick pin.
// RL12 - Watchdog cleared during reset, restarts timing when reset releases.
package svwd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint WDOG_TIME_MS  = 1600;
  localparam longint HOLD_TIME_MS  = 200;
  localparam longint DEBOUNCE_US   = 10_000;
  localparam longint WDOG_CYCLES   = CLK_HZ / 1000 * WDOG_TIME_MS;
  localparam longint HOLD_CYCLES   = CLK_HZ / 1000 * HOLD_TIME_MS;
  localparam longint DEBOUNCE_CYC  = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int     CNT_W         = 32;
  // Pin readback ignored this many cycles after release; covers sync lag
  localparam int     PIN_BLANK_W   = 3;

  // ----------------------------------------
  // Supervisor states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SVWD_HOLD,
    SVWD_TIMEOUT,
    SVWD_RUN
  } svwd_state_e;
endpackage

// File: test/svwd_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module svwd_mcu_model (
  input  wire logic       clk_in,
  input  wire logic       kick_en_in,
  input  wire logic [7:0] period_in,
  input  wire logic       pull_in,
  input  wire logic       oe_in,
  output var  logic       kick_out,
  output var  logic       pin_out
);
  logic [7:0] cnt = 8'h00;
  initial kick_out = 1'b0;
  always @(posedge clk_in) begin
    cnt <= (cnt >= period_in) ? 8'h00 : cnt + 8'h01;
    if (kick_en_in && cnt == 8'h00) begin
      kick_out <= !kick_out;
    end
  end
  assign pin_out = !(oe_in || pull_in);
endmodule
`default_nettype wire

// File: test/supervisor_watchdog_reset_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_reset_tb_top;
  import svwd_pkg::*;
  localparam logic [31:0] WD = 32'h0000_00c8;
  localparam logic [31:0] HD = 32'h0000_0032;
  logic clk_in = 0, rst_in = 1, sup = 0, man_n = 1, kpin = 0, wp = 0, req = 1;
  logic en = 0, pull = 0, sda, pin, rh, pd, oe, we;
  logic rh2, pd2, oe2, we2, pin2, rh_s, oe_s, we_s, rh2_s, oe2_s, we2_s;
  logic [7:0]  per = 8'h40;
  logic [31:0] lf  = 32'h8c8b_2c66;
  int mismatches = 0, checks_done = 0, cycles = 0;
  svwd_top #(.WDOG_CNT(WD), .HOLD_CNT(HD), .DEB_CNT(32'h0000_0004)) svwd_top_inst (
    .clk_in(clk_in), .rst_in(rst_in), .supply_low_in(sup), .manual_reset_in(man_n),
    .watchdog_kick_in(kpin), .sda_in(sda), .rst_n_pin_in(pin), .write_protect_in(wp),
    .write_req_in(req), .rst_high_out(rh), .rst_n_pin_out(pd), .rst_n_pin_oe_out(oe),
    .write_enable_out(we));
  svwd_mcu_model svwd_mcu_model_inst (.clk_in(clk_in), .kick_en_in(en), .period_in(per),
    .pull_in(pull), .oe_in(oe), .kick_out(sda), .pin_out(pin));
  // variant: dedicated kick pin, low reset only, no write protect
  if (1'b1) begin : g_variant
    svwd_top #(.WDOG_CNT(WD), .HOLD_CNT(HD), .DEB_CNT(32'h0000_0004), .HAS_KICK_PIN(1'b1),
      .HAS_HIGH_RST(1'b0), .HAS_WP(1'b0)) svwd_top_inst (
      .clk_in(clk_in), .rst_in(rst_in), .supply_low_in(sup), .manual_reset_in(man_n),
      .watchdog_kick_in(kpin), .sda_in(sda), .rst_n_pin_in(pin2), .write_protect_in(wp),
      .write_req_in(req), .rst_high_out(rh2), .rst_n_pin_out(pd2), .rst_n_pin_oe_out(oe2),
      .write_enable_out(we2));
  end
  assign pin2 = !oe2;
  // Outputs taken mid-cycle so checks never race the launching edge
  always @(negedge clk_in) begin
    {rh_s, oe_s, we_s, rh2_s, oe2_s, we2_s} <= {rh, oe, we, rh2, oe2, we2};
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_we(input logic rq, input logic prot, input logic low);
    return rq && !prot && !low;
  endfunction
  task automatic tally_and_finish();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic rst_is(input logic e);
    chk("rst_high", e, rh_s);
    chk("rst_oe", e, oe_s);
    chk("rst_drive", 1'b0, pd);
    chk("v_rst_drive", 1'b0, pd2);
    chk("v_rst_high", 1'b0, rh2_s);
  endtask
  task automatic rel_chk(input int extra);
    cyc(HD - 6);
    rst_is(1'b1);
    cyc(16 + extra);
    rst_is(1'b0);
  endtask
  // Bounded wait, kick enable left as the caller set it
  task automatic wait_rh(input logic e, input int lim);
    for (int n = 0; rh_s !== e && n < lim; n++) @(posedge clk_in);
    chk("rst_wait", e, rh_s);
  endtask
  initial begin
    forever #2.5 clk_in = !clk_in;
  end
  always @(posedge clk_in) begin
    kpin <= !kpin;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    cyc(8);
    rst_in <= 1'b0;
    en <= 1'b1;
    cyc(1);
    rel_chk(0);
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      per <= 8'd20 + 8'(lf % 100);
      cyc(50);
      rst_is(1'b0);
    end
    en <= 1'b0;
    wait_rh(1'b1, WD + 10);
    chk("v_kick_pin", 1'b0, oe2_s);
    rel_chk(0);
    cyc(WD - 80);
    rst_is(1'b0);
    en <= 1'b1;
    sup <= 1'b1;
    cyc(5);
    rst_is(1'b1);
    cyc(100);
    chk("we_low_supply", 1'b0, we_s);
    chk("v_we_low_supply", 1'b0, we2_s);
    sup <= 1'b0;
    rel_chk(0);
    man_n <= 1'b0;
    cyc(2);
    man_n <= 1'b1;
    cyc(10);
    rst_is(1'b0);
    man_n <= 1'b0;
    cyc(100);
    rst_is(1'b1);
    man_n <= 1'b1;
    rel_chk(6);
    pull <= 1'b1;
    cyc(20);
    chk("rst_pull", 1'b1, rh_s);
    chk("v_no_pull", 1'b0, oe2_s);
    pull <= 1'b0;
    wait_rh(1'b0, HD + 40);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      req <= lf[0];
      wp <= lf[1];
      cyc(5);
      chk("write_en", exp_we(lf[0], lf[1], 1'b0), we_s);
      chk("v_write_en", exp_we(lf[0], 1'b0, 1'b0), we2_s);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
